// ===== include/stsc_pkg.sv
// Shared constants and types for the temperature sensor core
package stsc_pkg;
   // Register select codes
   localparam logic [2:0] PTR_RESULT = 3'h0;
   localparam logic [2:0] PTR_CONFIG = 3'h1;
   localparam logic [2:0] PTR_UPPER = 3'h2;
   localparam logic [2:0] PTR_LOWER = 3'h3;
   localparam logic [2:0] PTR_CTRL = 3'h4;
   localparam logic [2:0] PTR_IDENT = 3'h7;
   // Reset and marker values
   localparam logic [15:0] RESULT_RST = 16'h7FFC;
   localparam logic [15:0] ONESHOT_VAL = 16'h8000;
   localparam logic [7:0] CONFIG_RST = 8'h40;
   localparam logic [15:0] UPPER_RST = 16'h7FE0;
   localparam logic [15:0] LOWER_RST = 16'h7FC0;
   localparam logic [1:0] RES_RST = 2'h0;
   // Identification value, arbitrary
   localparam logic [15:0] IDENT_VAL = 16'h0A5A;
   // Configuration bit positions
   localparam int CFG_PD = 7;
   localparam int CFG_ALDIS = 5;
   localparam int CFG_ALPOL = 4;
   localparam int CFG_ALRST = 3;
   localparam int CFG_OS = 2;
   // Control and status bit positions
   localparam int CTL_RES_HI = 6;
   localparam int CTL_RES_LO = 5;
   localparam int CTL_ALSTAT = 3;
   localparam int CTL_ABOVE = 2;
   localparam int CTL_BELOW = 1;
   localparam int CTL_VALID = 0;
   // Slave addresses
   localparam logic [6:0] ADDR_BASE_V0 = 7'h48;
   localparam logic [6:0] ADDR_BASE_V1 = 7'h4C;
   localparam logic [6:0] ADDR_ALERT_RESP = 7'h0C;
   localparam logic [1:0] APIN_FLOAT = 2'h0;
   localparam logic [1:0] APIN_GND = 2'h1;
   localparam logic [1:0] APIN_VDD = 2'h2;
   // Timing
   localparam int CLK_PERIOD_NS = 40;
   localparam int TIMEOUT_NS = 45000000;
   localparam int TIMEOUT_CYC = TIMEOUT_NS / CLK_PERIOD_NS;
   localparam int FILT_LEN = 3;
   localparam logic [15:0] RES_MASK_BASE = 16'h001F;
   // Bus state machine
   typedef enum logic [4:0] {
      S_IDLE = 5'b00001,
      S_RX = 5'b00010,
      S_ACK = 5'b00100,
      S_TX = 5'b01000,
      S_RACK = 5'b10000
   } stsc_bus_st_t;
   // Per-reading status
   typedef struct packed {
      logic alert;
      logic above;
      logic below;
      logic valid;
   } stsc_stat_t;
endpackage : stsc_pkg

// ===== rtl/stsc_core.sv
// Temperature sensor core: two-wire slave, registers, conversion control, alert
// What this block does
// - After reset every register holds its default until conversion or write.
// - In shutdown, writing one-shot starts exactly one conversion and compare.
// - During a one-shot, valid flag reads zero and result reads 8000h.
// - One-shot completion sets the valid flag and loads the measured result.
// - Two resolution bits select 11, 12, 13 or 14 bit results.
// - Default resolution is 11 bits, quarter degree per step.
// - Result is two's complement, left-justified, unused low bits zero.
// - Bit 7 weighs one degree at every resolution.
// - Slave only; clock line is never driven, no stretching.
// - Version 0 address pin picks 1001000, 1001001 or 1001010.
// - Version 1 address pin picks 1001100, 1001101 or 1001110.
// - Data line is open-drain: pull low or release only.
// - Either line low past timeout returns bus logic to idle, releases data.
// - Bus timeout expires within 45 ms of a line held low.
// - Each completion compares with upper limit; above sets alert and status.
// - Alert clears below lower limit, by reset bit, or alert response read.
// - Alert cleared by reset bit reasserts on next conversion still above.
// - Each reading sets above-upper and below-lower flags.
// - Limit comparisons use only the 11-bit form of the result.
// - Pointer resets to result register and keeps its last value.
// - Undefined pointer values are not acknowledged nor stored.
// - Pointer codes 0,1,2,3,4,7 select registers; upper bits zero.
// - Entering shutdown finishes the running conversion and updates results.
`timescale 1ns/1ps
module stsc_core #(
   parameter int VERSION = 0,
   parameter int TIMEOUT_CYCLES = stsc_pkg::TIMEOUT_CYC,
   parameter int ADC_W = 14
) (
   input wire logic MCLK,
   input wire logic RESET,
   input wire logic CE,
   input wire logic SCL_IN,
   input wire logic SDA_IN,
   output logic SDA_OUT,
   output logic SDA_OE,
   input wire logic [1:0] ADDR_SEL,
   output logic ALERT_OUT,
   output logic ALERT_OE,
   input wire logic CONV_CLK,
   output logic ADC_START,
   output logic [1:0] ADC_RES,
   input wire logic ADC_DONE,
   input wire logic [ADC_W-1:0] ADC_DATA
);
   import stsc_pkg::*;

   localparam int TW = $clog2(TIMEOUT_CYCLES + 1);
   localparam logic [TW-1:0] TO_LAST = TW'(TIMEOUT_CYCLES);

   stsc_bus_st_t state_ff;
   stsc_stat_t stat_ff;
   logic scl_s1_ff, scl_s2_ff, sda_s1_ff, sda_s2_ff;
   logic [FILT_LEN-1:0] scl_h_ff, sda_h_ff;
   logic scl_f_ff, sda_f_ff, scl_q_ff, sda_q_ff;
   logic [1:0] apin_s1_ff, apin_s2_ff;
   logic scl_rise, scl_fall, start_c, stop_c;
   logic [TW-1:0] to_cnt_ff;
   logic tout;
   logic [3:0] cnt_ff;
   logic [2:0] idx_ff;
   logic [7:0] shreg_ff, txsh_ff, tx_byte, rx_byte, hold_ff;
   logic ack_ok_ff, rw_ff, ara_ff, rd_lo_ff, sda_oe_ff;
   logic byte_done, ack_calc, wr_evt, bad_ptr_evt, ara_clr;
   logic [6:0] own_addr;
   logic [2:0] ptr_ff;
   logic [7:0] cfg_ff;
   logic [1:0] res_ff;
   logic [15:0] upper_ff, lower_ff, result_ff, res_mask, adc_word;
   logic os_wr, alrst_wr, alert_oe_ff;
   logic req_ff, ack_s1_ff, ack_s2_ff, ack_q_ff, pend_ff, cur_os_ff;
   logic done_evt, upd, launch, cmp_hi, cmp_lo;
   logic rst_c1_ff, rst_c2_ff, req_c1_ff, req_c2_ff, cack_ff;
   logic [ADC_W-1:0] cdata_ff;

   // Input synchronisers
   always_ff @(posedge MCLK) begin
      if (RESET) begin
         scl_s1_ff <= 1'b1;
         scl_s2_ff <= 1'b1;
         sda_s1_ff <= 1'b1;
         sda_s2_ff <= 1'b1;
         apin_s1_ff <= APIN_FLOAT;
         apin_s2_ff <= APIN_FLOAT;
      end else if (CE) begin
         scl_s1_ff <= SCL_IN;
         scl_s2_ff <= scl_s1_ff;
         sda_s1_ff <= SDA_IN;
         sda_s2_ff <= sda_s1_ff;
         apin_s1_ff <= ADDR_SEL;
         apin_s2_ff <= apin_s1_ff;
      end
   end

   // Glitch filter: a level passes only after FILT_LEN equal samples
   always_ff @(posedge MCLK) begin
      if (RESET) begin
         scl_h_ff <= '1;
         sda_h_ff <= '1;
         scl_f_ff <= 1'b1;
         sda_f_ff <= 1'b1;
         scl_q_ff <= 1'b1;
         sda_q_ff <= 1'b1;
      end else if (CE) begin
         scl_h_ff <= {scl_h_ff[FILT_LEN-2:0], scl_s2_ff};
         sda_h_ff <= {sda_h_ff[FILT_LEN-2:0], sda_s2_ff};
         if (&scl_h_ff) begin
            scl_f_ff <= 1'b1;
         end else if (~|scl_h_ff) begin
            scl_f_ff <= 1'b0;
         end
         if (&sda_h_ff) begin
            sda_f_ff <= 1'b1;
         end else if (~|sda_h_ff) begin
            sda_f_ff <= 1'b0;
         end
         scl_q_ff <= scl_f_ff;
         sda_q_ff <= sda_f_ff;
      end
   end

   assign scl_rise = scl_f_ff & ~scl_q_ff;
   assign scl_fall = ~scl_f_ff & scl_q_ff;
   assign start_c = scl_f_ff & scl_q_ff & sda_q_ff & ~sda_f_ff;
   assign stop_c = scl_f_ff & scl_q_ff & ~sda_q_ff & sda_f_ff;

   // Own address from version and address pin
   always_comb begin
      own_addr = (VERSION == 0) ? ADDR_BASE_V0 : ADDR_BASE_V1;
      if (apin_s2_ff == APIN_GND) begin
         own_addr = own_addr + 7'h1;
      end else if (apin_s2_ff == APIN_VDD) begin
         own_addr = own_addr + 7'h2;
      end
   end

   // Low-time counter for bus timeout
   always_ff @(posedge MCLK) begin
      if (RESET) begin
         to_cnt_ff <= '0;
      end else if (CE) begin
         if (scl_f_ff & sda_f_ff) begin
            to_cnt_ff <= '0;
         end else if (to_cnt_ff != TO_LAST) begin
            to_cnt_ff <= to_cnt_ff + TW'(1);
         end
      end
   end

   assign tout = (to_cnt_ff == TO_LAST - TW'(1)) & ~(scl_f_ff & sda_f_ff);

   // Byte decode at the eighth clock rise
   assign rx_byte = {shreg_ff[6:0], sda_f_ff};
   assign byte_done = (state_ff == S_RX) & scl_rise & (cnt_ff == 4'h7);
   always_comb begin
      ack_calc = 1'b1;
      if (idx_ff == 3'h0) begin
         ack_calc = (rx_byte[7:1] == own_addr) |
            ((rx_byte[7:1] == ADDR_ALERT_RESP) & rx_byte[0] & stat_ff.alert);
      end else if (idx_ff == 3'h1) begin
         ack_calc = (rx_byte[7:3] == 5'h00) & (rx_byte[2:0] != 3'h5) & (rx_byte[2:0] != 3'h6);
      end
   end

   assign wr_evt = CE & (state_ff == S_RX) & scl_fall & (cnt_ff == 4'h8) & ack_ok_ff & ~rw_ff;
   assign bad_ptr_evt = CE & (state_ff == S_RX) & scl_fall & (cnt_ff == 4'h8) & ~ack_ok_ff & (idx_ff == 3'h1);
   assign ara_clr = CE & (state_ff == S_RACK) & scl_rise & ara_ff;

   // Slave bus state machine
   always_ff @(posedge MCLK) begin
      if (RESET) begin
         state_ff <= S_IDLE;
         cnt_ff <= 4'h0;
         idx_ff <= 3'h0;
         shreg_ff <= 8'h00;
         txsh_ff <= 8'h00;
         ack_ok_ff <= 1'b0;
         rw_ff <= 1'b0;
         ara_ff <= 1'b0;
         rd_lo_ff <= 1'b0;
         sda_oe_ff <= 1'b0;
      end else if (CE) begin
         if (tout | stop_c) begin
            state_ff <= S_IDLE;
            sda_oe_ff <= 1'b0;
         end else if (start_c) begin
            state_ff <= S_RX;
            cnt_ff <= 4'h0;
            idx_ff <= 3'h0;
            sda_oe_ff <= 1'b0;
         end else begin
            unique case (state_ff)
               S_IDLE: begin
                  sda_oe_ff <= 1'b0;
               end
               S_RX: begin
                  if (scl_rise) begin
                     shreg_ff <= rx_byte;
                     cnt_ff <= cnt_ff + 4'h1;
                     if (byte_done) begin
                        ack_ok_ff <= ack_calc;
                     end
                  end else if (scl_fall & (cnt_ff == 4'h8)) begin
                     state_ff <= S_ACK;
                     sda_oe_ff <= ack_ok_ff;
                     if (idx_ff == 3'h0) begin
                        rw_ff <= shreg_ff[0];
                        ara_ff <= (shreg_ff[7:1] == ADDR_ALERT_RESP);
                        rd_lo_ff <= 1'b0;
                     end
                     if (idx_ff != 3'h4) begin
                        idx_ff <= idx_ff + 3'h1;
                     end
                  end
               end
               S_ACK: begin
                  if (scl_fall) begin
                     cnt_ff <= (ack_ok_ff & rw_ff) ? 4'h1 : 4'h0;
                     if (!ack_ok_ff) begin
                        state_ff <= S_IDLE;
                        sda_oe_ff <= 1'b0;
                     end else if (rw_ff) begin
                        state_ff <= S_TX;
                        txsh_ff <= tx_byte;
                        sda_oe_ff <= ~tx_byte[7];
                     end else begin
                        state_ff <= S_RX;
                        sda_oe_ff <= 1'b0;
                     end
                  end
               end
               S_TX: begin
                  if (scl_fall) begin
                     if (cnt_ff == 4'h8) begin
                        state_ff <= S_RACK;
                        sda_oe_ff <= 1'b0;
                     end else begin
                        txsh_ff <= {txsh_ff[6:0], 1'b0};
                        sda_oe_ff <= ~txsh_ff[6];
                        cnt_ff <= cnt_ff + 4'h1;
                     end
                  end
               end
               S_RACK: begin
                  if (scl_rise) begin
                     rd_lo_ff <= ~rd_lo_ff;
                     if (sda_f_ff | ara_ff) begin
                        state_ff <= S_IDLE;
                     end
                  end else if (scl_fall) begin
                     state_ff <= S_TX;
                     txsh_ff <= tx_byte;
                     sda_oe_ff <= ~tx_byte[7];
                     cnt_ff <= 4'h1;
                  end
               end
            endcase
         end
      end
   end

   assign SDA_OE = sda_oe_ff;
   assign SDA_OUT = 1'b0;

   // Read data mux
   always_comb begin
      tx_byte = 8'h00;
      if (ara_ff) begin
         tx_byte = {own_addr, 1'b0};
      end else begin
         case (ptr_ff)
            PTR_RESULT: tx_byte = rd_lo_ff ? result_ff[7:0] : result_ff[15:8];
            PTR_CONFIG: tx_byte = cfg_ff;
            PTR_UPPER: tx_byte = rd_lo_ff ? upper_ff[7:0] : upper_ff[15:8];
            PTR_LOWER: tx_byte = rd_lo_ff ? lower_ff[7:0] : lower_ff[15:8];
            PTR_CTRL: tx_byte = {1'b0, res_ff, 1'b0, stat_ff};
            PTR_IDENT: tx_byte = rd_lo_ff ? IDENT_VAL[7:0] : IDENT_VAL[15:8];
            default: tx_byte = 8'h00;
         endcase
      end
   end

   assign os_wr = wr_evt & (idx_ff == 3'h2) & (ptr_ff == PTR_CONFIG) & shreg_ff[CFG_OS] & shreg_ff[CFG_PD];
   assign alrst_wr = wr_evt & (idx_ff == 3'h2) & (ptr_ff == PTR_CONFIG) & shreg_ff[CFG_ALRST];

   // Host-writable registers
   always_ff @(posedge MCLK) begin
      if (RESET) begin
         ptr_ff <= PTR_RESULT;
         cfg_ff <= CONFIG_RST;
         res_ff <= RES_RST;
         upper_ff <= UPPER_RST;
         lower_ff <= LOWER_RST;
         hold_ff <= 8'h00;
      end else if (wr_evt) begin
         if (idx_ff == 3'h1) begin
            ptr_ff <= shreg_ff[2:0];
         end else if (idx_ff == 3'h2) begin
            hold_ff <= shreg_ff;
            if (ptr_ff == PTR_CONFIG) begin
               cfg_ff <= shreg_ff & ~(8'h01 << CFG_OS) & ~(8'h01 << CFG_ALRST);
            end else if (ptr_ff == PTR_CTRL) begin
               res_ff <= shreg_ff[CTL_RES_HI:CTL_RES_LO];
            end
         end else if (idx_ff == 3'h3) begin
            if (ptr_ff == PTR_UPPER) begin
               upper_ff <= {hold_ff, shreg_ff};
            end else if (ptr_ff == PTR_LOWER) begin
               lower_ff <= {hold_ff, shreg_ff};
            end
         end
      end
   end

   assign ADC_RES = res_ff;

   // Conversion request handshake, clock side
   assign done_evt = ack_s2_ff & ~ack_q_ff;
   assign launch = ~req_ff & ~ack_s2_ff & ~ack_q_ff & (~cfg_ff[CFG_PD] | pend_ff);
   assign upd = done_evt & (~pend_ff | cur_os_ff);
   always_ff @(posedge MCLK) begin
      if (RESET) begin
         req_ff <= 1'b0;
         ack_s1_ff <= 1'b0;
         ack_s2_ff <= 1'b0;
         ack_q_ff <= 1'b0;
         pend_ff <= 1'b0;
         cur_os_ff <= 1'b0;
      end else if (CE) begin
         ack_s1_ff <= cack_ff;
         ack_s2_ff <= ack_s1_ff;
         ack_q_ff <= ack_s2_ff;
         if (launch) begin
            req_ff <= 1'b1;
            cur_os_ff <= pend_ff;
         end else if (done_evt) begin
            req_ff <= 1'b0;
         end
         if (os_wr) begin
            pend_ff <= 1'b1;
         end else if (done_evt & cur_os_ff) begin
            pend_ff <= 1'b0;
         end
      end
   end

   // Result formatting and limit compare on 11 bits
   assign res_mask = ~(RES_MASK_BASE >> res_ff);
   assign adc_word = {cdata_ff, 2'b00} & res_mask;
   assign cmp_hi = $signed(adc_word[15:5]) > $signed(upper_ff[15:5]);
   assign cmp_lo = $signed(adc_word[15:5]) < $signed(lower_ff[15:5]);

   // Result and status
   always_ff @(posedge MCLK) begin
      if (RESET) begin
         result_ff <= RESULT_RST;
         stat_ff <= '0;
      end else if (CE) begin
         if (os_wr) begin
            result_ff <= ONESHOT_VAL;
            stat_ff.valid <= 1'b0;
         end else if (upd) begin
            result_ff <= adc_word;
            stat_ff.valid <= 1'b1;
         end
         if (upd) begin
            stat_ff.above <= cmp_hi;
            stat_ff.below <= cmp_lo;
         end
         if (upd & cmp_hi) begin
            stat_ff.alert <= 1'b1;
         end else if ((upd & cmp_lo) | alrst_wr | ara_clr) begin
            stat_ff.alert <= 1'b0;
         end
      end
   end

   // Alert pin, open-drain
   always_ff @(posedge MCLK) begin
      if (RESET) begin
         alert_oe_ff <= 1'b0;
      end else if (CE) begin
         alert_oe_ff <= ~cfg_ff[CFG_ALDIS] & (stat_ff.alert ^ cfg_ff[CFG_ALPOL]);
      end
   end
   assign ALERT_OE = alert_oe_ff;
   assign ALERT_OUT = 1'b0;

   // Conversion clock side
   always_ff @(posedge CONV_CLK) begin
      rst_c1_ff <= RESET;
      rst_c2_ff <= rst_c1_ff;
   end
   always_ff @(posedge CONV_CLK) begin
      if (rst_c2_ff) begin
         req_c1_ff <= 1'b0;
         req_c2_ff <= 1'b0;
         cack_ff <= 1'b0;
         cdata_ff <= '0;
      end else begin
         req_c1_ff <= req_ff;
         req_c2_ff <= req_c1_ff;
         if (ADC_START & ADC_DONE) begin
            cdata_ff <= ADC_DATA;
            cack_ff <= 1'b1;
         end else if (!req_c2_ff) begin
            cack_ff <= 1'b0;
         end
      end
   end
   assign ADC_START = req_c2_ff & ~cack_ff;

   // Checks
   default clocking cb @(posedge MCLK); endclocking
   default disable iff (RESET);

   chk_idle_released: assert property (state_ff == S_IDLE && $past(state_ff) == S_IDLE |-> !SDA_OE)
      else $error("data line driven while idle");
   chk_timeout_idle: assert property (CE && tout |=> state_ff == S_IDLE && !SDA_OE)
      else $error("timeout did not release bus");
   chk_timeout_bound: assert property (to_cnt_ff == TO_LAST |-> state_ff == S_IDLE && !SDA_OE)
      else $error("bus not idle at timeout limit");
   chk_oneshot_mark: assert property (CE && os_wr |=> result_ff == ONESHOT_VAL && !stat_ff.valid)
      else $error("one-shot marker missing");
   chk_low_bits_zero: assert property (CE && upd && !os_wr |=> (result_ff & ~$past(res_mask)) == 16'h0000)
      else $error("bits below resolution set");
   chk_alert_raise: assert property (CE && upd && cmp_hi |=> stat_ff.alert)
      else $error("alert not raised above upper limit");
   chk_alert_reset: assert property (CE && alrst_wr && !(upd && cmp_hi) |=> !stat_ff.alert)
      else $error("alert reset ignored");
   chk_flags_track: assert property (CE && upd |=> stat_ff.above == $past(cmp_hi) && stat_ff.below == $past(cmp_lo))
      else $error("limit flags wrong");
   chk_ptr_keep: assert property (CE && bad_ptr_evt |=> $stable(ptr_ff))
      else $error("bad pointer stored");
   chk_run_free: assert property (CE && !cfg_ff[CFG_PD] && !req_ff && !ack_s2_ff && !ack_q_ff |=> req_ff)
      else $error("free-running conversion stalled");

   cov_oneshot: cover property (os_wr ##[1:1000] upd);
   cov_alert: cover property (upd && cmp_hi);
   cov_timeout: cover property (tout);
   cov_ara: cover property (ara_clr);
endmodule : stsc_core

// ===== testbench/stsc_host_model.sv
// SMBus host model driving the bus clock
`timescale 1ns/1ps
module stsc_host_model (
   input wire logic MCLK,
   input wire logic SDA_LINE,
   output logic SCL = 1'b1,
   output logic SDA_LOW = 1'b0,
   output logic RD_STB = 1'b0,
   output logic [15:0] RD_DATA
);
   int stalls = 0;
   task wq;
      repeat (10) @(negedge MCLK);
   endtask : wq
   task hbit(input logic b, output logic r);
      SDA_LOW = ~b;
      wq();
      SCL = 1'b1;
      wq();
      r = SDA_LINE;
      wq();
      SCL = 1'b0;
      wq();
   endtask : hbit
   task hstart;
      SDA_LOW = 1'b0;
      wq();
      SCL = 1'b1;
      for (int n = 0; n < 99 && SDA_LINE !== 1'b1; n++) @(negedge MCLK);
      if (SDA_LINE !== 1'b1) stalls++;
      wq();
      SDA_LOW = 1'b1;
      wq();
      SCL = 1'b0;
      wq();
   endtask : hstart
   task hstop;
      SDA_LOW = 1'b1;
      wq();
      SCL = 1'b1;
      wq();
      SDA_LOW = 1'b0;
      wq();
   endtask : hstop
   task hsend(input logic [7:0] b, output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--) hbit(b[i], r);
      hbit(1'b1, r);
      ack = ~r;
   endtask : hsend
   task hrecv(input logic last, output logic [7:0] d);
      logic r;
      for (int i = 7; i >= 0; i--) hbit(1'b1, d[i]);
      hbit(last, r);
   endtask : hrecv
   task write_reg(input logic [6:0] a, input logic [7:0] p, input int n, input logic [15:0] d, output logic ok);
      logic k;
      hstart();
      hsend({a, 1'b0}, ok);
      hsend(p, k);
      ok &= k;
      if (n == 2) begin
         hsend(d[15:8], k);
         ok &= k;
      end
      if (n > 0) begin
         hsend(d[7:0], k);
         ok &= k;
      end
      hstop();
   endtask : write_reg
   task read_reg(input logic [6:0] a, input logic [7:0] p, input int n, output logic ok);
      logic k;
      logic [7:0] hi, lo;
      ok = 1'b1;
      hstart();
      if (p != 8'hFF) begin
         hsend({a, 1'b0}, k);
         ok &= k;
         hsend(p, k);
         ok &= k;
         hstart();
      end
      hsend({a, 1'b1}, k);
      ok &= k;
      hrecv(n == 1, hi);
      if (n == 2) hrecv(1'b1, lo);
      hstop();
      RD_DATA = (n == 2) ? {hi, lo} : {8'h00, hi};
      RD_STB = 1'b1;
      @(negedge MCLK);
      RD_STB = 1'b0;
   endtask : read_reg
endmodule : stsc_host_model

// ===== testbench/tb_stsc_core.sv
// Testbench for the temperature sensor core
`timescale 1ns/1ps
module tb_stsc_core;
   import stsc_pkg::*;
   logic MCLK = 1'b0, CONV_CLK = 1'b0, RESET = 1'b1, ADC_DONE = 1'b0;
   logic [1:0] ADDR_SEL = 2'h0, ADC_RES;
   logic [13:0] ADC_DATA = 14'h0, adc_val = 14'h0;
   logic SDA_OUT, SDA_OE, ALERT_OUT, ALERT_OE, ADC_START, scl, sda_low, rd_stb, ok;
   logic adc_en = 1'b0, armed = 1'b1;
   logic [15:0] rd_data;
   logic [15:0] exp_q[$];
   logic [7:0] bad[4] = '{8'h05, 8'h06, 8'h0F, 8'h80};
   logic [13:0] deg[2] = '{14'h0020, 14'h3FE0};
   int mismatches = 0, samples_checked = 0, done_cnt = 0, cnt = 0, seed = 9, s0;
   wire sda_line = (SDA_OE ? SDA_OUT : 1'b1) & ~sda_low;
   always #20 MCLK = ~MCLK;
   initial begin
      #13;
      forever #40 CONV_CLK = ~CONV_CLK;
   end
   stsc_core #(.VERSION(0), .TIMEOUT_CYCLES(2000)) dut_u (.MCLK(MCLK), .RESET(RESET), .CE(1'b1),
      .SCL_IN(scl), .SDA_IN(sda_line), .SDA_OUT(SDA_OUT), .SDA_OE(SDA_OE), .ADDR_SEL(ADDR_SEL),
      .ALERT_OUT(ALERT_OUT), .ALERT_OE(ALERT_OE), .CONV_CLK(CONV_CLK), .ADC_START(ADC_START),
      .ADC_RES(ADC_RES), .ADC_DONE(ADC_DONE), .ADC_DATA(ADC_DATA));
   stsc_host_model host_u (.MCLK(MCLK), .SDA_LINE(sda_line), .SCL(scl), .SDA_LOW(sda_low),
      .RD_STB(rd_stb), .RD_DATA(rd_data));
   // Analogue core stand-in
   always @(negedge CONV_CLK) begin
      ADC_DONE <= 1'b0;
      ADC_DATA <= ~adc_val;
      if (ADC_START !== 1'b1) begin
         armed <= 1'b1;
         cnt <= 0;
      end else if (armed && adc_en) begin
         cnt <= cnt + 1;
         if (cnt == 3) begin
            ADC_DONE <= 1'b1;
            ADC_DATA <= adc_val;
            armed <= 1'b0;
            done_cnt <= done_cnt + 1;
         end
      end
   end
   task check(input logic [15:0] seen, input logic [15:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         mismatches++;
         $display("[FAIL] %0t got %h expected %h", $time, seen, exp);
      end
   endtask : check
   task summarize;
      $display("Checks %0d, mismatches %0d", samples_checked, mismatches);
      if (mismatches == 0 && samples_checked > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask : summarize
   always @(posedge MCLK)
      if (rd_stb === 1'b1) check(rd_data, (exp_q.size() > 0) ? exp_q.pop_front() : 16'hXXXX);
   task rd(input logic [7:0] p, input int n, input logic [15:0] e);
      exp_q.push_back(e);
      host_u.read_reg(ADDR_BASE_V0, p, n, ok);
      check(16'(ok), 16'h1);
   endtask : rd
   task wr(input logic [7:0] p, input int n, input logic [15:0] d);
      host_u.write_reg(ADDR_BASE_V0, p, n, d, ok);
      check(16'(ok), 16'h1);
   endtask : wr
   task conv(input int n);
      int s, t;
      s = done_cnt;
      for (t = 0; t < 20000 && done_cnt < s + n; t++) @(negedge MCLK);
      if (t == 20000) begin
         mismatches++;
         summarize();
      end
      repeat (30) @(negedge MCLK);
   endtask : conv
   initial begin
      repeat (6) @(negedge MCLK);
      RESET = 1'b0;
      repeat (20) @(negedge MCLK);
      rd(8'hFF, 2, RESULT_RST);
      rd(8'h01, 1, {8'h00, CONFIG_RST});
      rd(8'h02, 2, UPPER_RST);
      rd(8'h03, 2, LOWER_RST);
      rd(8'h04, 1, 16'h0);
      rd(8'h07, 2, IDENT_VAL);
      foreach (bad[i]) begin
         host_u.write_reg(ADDR_BASE_V0, bad[i], 0, 16'h0, ok);
         check(16'(ok), 16'h0);
      end
      rd(8'hFF, 2, IDENT_VAL);
      adc_en = 1'b1;
      for (int r = 0; r < 4; r++) begin
         wr(8'h04, 1, 16'(r * 32));
         adc_val = 14'($random(seed));
         conv(2);
         rd(8'h00, 2, {adc_val, 2'b00} & ~(RES_MASK_BASE >> r));
      end
      foreach (deg[i]) begin
         adc_val = deg[i];
         conv(2);
         rd(8'h00, 2, {deg[i], 2'b00});
      end
      wr(8'h02, 2, 16'h0100);
      wr(8'h03, 2, 16'h0080);
      adc_val = 14'd67;
      conv(2);
      check(16'(ALERT_OE), 16'h0);
      rd(8'h04, 1, 16'h0061);
      adc_val = 14'd72;
      conv(2);
      check(16'(ALERT_OE), 16'h1);
      rd(8'h04, 1, 16'h006D);
      adc_en = 1'b0;
      wr(8'h01, 1, 16'h0048);
      repeat (10) @(negedge MCLK);
      check(16'(ALERT_OE), 16'h0);
      adc_en = 1'b1;
      conv(1);
      check(16'(ALERT_OE), 16'h1);
      adc_en = 1'b0;
      exp_q.push_back(16'({ADDR_BASE_V0, 1'b0}));
      host_u.read_reg(ADDR_ALERT_RESP, 8'hFF, 1, ok);
      check(16'(ok), 16'h1);
      check(16'(ALERT_OE), 16'h0);
      adc_en = 1'b1;
      conv(1);
      check(16'(ALERT_OE), 16'h1);
      adc_val = 14'd8;
      conv(2);
      check(16'(ALERT_OE), 16'h0);
      rd(8'h04, 1, 16'h0063);
      adc_en = 1'b0;
      wr(8'h01, 1, 16'h00C0);
      adc_val = 14'd16;
      adc_en = 1'b1;
      repeat (400) @(negedge MCLK);
      check(16'(ADC_START), 16'h0);
      rd(8'h00, 2, 16'h0040);
      adc_en = 1'b0;
      s0 = done_cnt;
      wr(8'h01, 1, 16'h00C4);
      rd(8'h00, 2, ONESHOT_VAL);
      rd(8'h04, 1, 16'h0062);
      adc_val = 14'd40;
      adc_en = 1'b1;
      repeat (400) @(negedge MCLK);
      check(16'(done_cnt - s0), 16'h1);
      rd(8'h00, 2, 16'h00A0);
      rd(8'h04, 1, 16'h0061);
      for (int s = 0; s < 4; s++) begin
         ADDR_SEL = s[1:0];
         repeat (5) @(negedge MCLK);
         for (int o = 0; o < 3; o++) begin
            host_u.hstart();
            host_u.hsend({ADDR_BASE_V0 + 7'(o), 1'b0}, ok);
            host_u.hstop();
            check(16'(ok), 16'(o == s % 3));
         end
      end
      host_u.hstart();
      host_u.hsend({ADDR_BASE_V0, 1'b1}, ok);
      repeat (20) @(negedge MCLK);
      check(16'(SDA_OE), 16'h1);
      repeat (2100) @(negedge MCLK);
      check(16'(SDA_OE), 16'h0);
      host_u.hstop();
      rd(8'h07, 2, IDENT_VAL);
      check(16'(host_u.stalls), 16'h0);
      summarize();
   end
endmodule : tb_stsc_core
